// File: freq_prot_pkg.sv
// Constants, types and helper functions of the frequency protection element.
// Overview of operation
// - Gradient mode: violation gives alarm, starts delay.
// - Gradient mode trips if still violated at expiry.
// - Sign selects rising, falling or both directions.
// - Under-plus-gradient needs low frequency and gradient.
// - Over-plus-gradient needs high frequency and gradient.
// - Combined modes: both conditions give alarm, delay.
// - Combined modes trip if both hold at expiry.
// - Interval modes: crossing gives alarm, starts interval.
// - Trip when change reached inside the interval.
// - Interval expiry inhibits until a new crossing.
// - Change is decrease for under, increase for over.
// - Each zero crossing measures cycle against reference.
// - Surge in enough phases trips at once.
// - Low voltage inhibits surge, faster than detection.
// - Lost phase inhibits surge tripping.
// - Surge detected within sixty milliseconds.
// - Slow frequency drift never counts as surge.
// - Recovery keeps blocking 0.5 s, zero frequency 0.3 s.
// - Gradient window limited to two to ten periods.
package freq_prot_pkg;
   localparam int FREQ_W = 16;
   localparam int GRAD_W = 16;
   localparam int MS_W = 16;
   localparam int CYC_W = 24;
   localparam int REC_W = 25;
   localparam int WIN_W = 4;
   localparam int CLK_HZ = 50000000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int BLOCK_HOLD_MS = 500;
   localparam int FREQ_ZERO_MS = 300;
   localparam int SURGE_LATENCY_MS = 60;
   localparam int BLOCK_HOLD_CYCLES = BLOCK_HOLD_MS * MS_CYCLES;
   localparam int FREQ_ZERO_CYCLES = FREQ_ZERO_MS * MS_CYCLES;
   localparam int SURGE_LATENCY_CYCLES = SURGE_LATENCY_MS * MS_CYCLES;
   localparam logic [WIN_W-1:0] WINDOW_MIN = 4'h2;
   localparam logic [WIN_W-1:0] WINDOW_MAX = 4'hA;
   localparam logic [WIN_W-1:0] WINDOW_RESET = WINDOW_MIN;
   localparam logic [REC_W-1:0] RECOVERY_RESET = 25'h0000000;
   localparam logic [FREQ_W-1:0] REPORT_RESET = 16'h0000;

   typedef enum logic [2:0] {
      MODE_GRADIENT,
      MODE_UNDER_GRAD,
      MODE_OVER_GRAD,
      MODE_UNDER_CHANGE,
      MODE_OVER_CHANGE,
      MODE_SURGE
   } mode_type;

   typedef enum logic [1:0] {
      SIGN_POS,
      SIGN_NEG,
      SIGN_ABS
   } sign_type;

   typedef enum logic [1:0] {
      SURGE_ALL,
      SURGE_TWO,
      SURGE_ONE
   } surge_count_type;

   // True when the frequency lies beyond the pickup threshold.
   function automatic logic beyond(input logic [FREQ_W-1:0] freq, input logic [FREQ_W-1:0] thr,
                                   input logic over);
      beyond = over ? (freq > thr) : (freq < thr);
   endfunction

   // True when the gradient violates the magnitude threshold in the selected direction.
   function automatic logic grad_violate(input logic signed [GRAD_W-1:0] grad,
                                         input logic [GRAD_W-2:0] thr, input sign_type sign);
      logic signed [GRAD_W-1:0] lim;
      lim = signed'({1'b0, thr});
      case (sign)
         SIGN_POS: grad_violate = grad >= lim;
         SIGN_NEG: grad_violate = grad <= -lim;
         SIGN_ABS: grad_violate = (grad >= lim) || (grad <= -lim);
         default: grad_violate = 1'b0;
      endcase
   endfunction

   // True when the change since the start sample reaches the threshold.
   function automatic logic change_reached(input logic [FREQ_W-1:0] start, input logic [FREQ_W-1:0] now,
                                           input logic [FREQ_W-1:0] thr, input logic over);
      if (over)
         change_reached = (now >= start) && ((now - start) >= thr);
      else
         change_reached = (start >= now) && ((start - now) >= thr);
   endfunction
endpackage

// File: delay_timer.sv
// Millisecond delay timer used for the trip delay and the supervision interval.
`timescale 1ns/1ps
module delay_timer #(
   parameter int MS_CYCLES = freq_prot_pkg::MS_CYCLES
) (
   input logic ref_clk,
   input logic nrst,
   input logic run,
   input logic [freq_prot_pkg::MS_W-1:0] limit_ms,
   output logic expired
);
   typedef struct packed {
      logic [freq_prot_pkg::CYC_W-1:0] prescale;
      logic [freq_prot_pkg::MS_W-1:0] ms;
      logic expired;
   } timer_state_type;

   timer_state_type state;
   timer_state_type next_state;

   always_comb
   begin
      next_state = state;
      if (!run)
      begin
         next_state = '0;
      end
      else if (!state.expired)
      begin
         if (state.prescale == freq_prot_pkg::CYC_W'(MS_CYCLES - 1))
         begin
            next_state.prescale = '0;
            next_state.ms = state.ms + 16'h0001;
         end
         else
         begin
            next_state.prescale = state.prescale + 24'h000001;
         end
         next_state.expired = next_state.ms >= limit_ms;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         state <= '0;
      else
         state <= next_state;
   end

   assign expired = state.expired;
endmodule // delay_timer

// File: surge_meter.sv
// Cycle duration meter of one phase for vector surge detection.
`timescale 1ns/1ps
module surge_meter #(
   parameter int LATENCY_CYCLES = freq_prot_pkg::SURGE_LATENCY_CYCLES
) (
   input logic ref_clk,
   input logic nrst,
   input logic hold,
   input logic zero_cross,
   input logic [freq_prot_pkg::CYC_W-1:0] threshold,
   output logic surge
);
   typedef struct packed {
      logic [freq_prot_pkg::CYC_W-1:0] count;
      logic [freq_prot_pkg::CYC_W-1:0] ref_time;
      logic ref_valid;
      logic surge;
   } meter_state_type;

   meter_state_type state;
   meter_state_type next_state;
   logic [freq_prot_pkg::CYC_W-1:0] deviation;

   always_comb
   begin
      next_state = state;
      deviation = (state.count > state.ref_time) ? state.count - state.ref_time : state.ref_time - state.count;
      if (hold)
      begin
         next_state = '0;
      end
      else if (zero_cross)
      begin
         next_state.surge = state.ref_valid && (deviation > threshold);
         next_state.ref_time = state.count;
         next_state.ref_valid = 1'b1;
         next_state.count = 24'h000001;
      end
      else if (state.count >= freq_prot_pkg::CYC_W'(LATENCY_CYCLES))
      begin
         next_state.ref_valid = 1'b0;
         next_state.surge = 1'b0;
      end
      else
      begin
         next_state.count = state.count + 24'h000001;
         if (state.ref_valid && (state.count > state.ref_time) && (deviation > threshold))
            next_state.surge = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         state <= '0;
      else
         state <= next_state;
   end

   assign surge = state.surge;
endmodule // surge_meter

// File: frequency_protection_element.sv
// Top level decision logic of one frequency protection element.
`timescale 1ns/1ps
module frequency_protection_element #(
   parameter int MS_CYCLES = freq_prot_pkg::MS_CYCLES,
   parameter int BLOCK_HOLD_CYCLES = freq_prot_pkg::BLOCK_HOLD_CYCLES,
   parameter int FREQ_ZERO_CYCLES = freq_prot_pkg::FREQ_ZERO_CYCLES,
   parameter int SURGE_LATENCY_CYCLES = freq_prot_pkg::SURGE_LATENCY_CYCLES
) (
   input logic ref_clk,
   input logic nrst,
   input freq_prot_pkg::mode_type mode,
   input freq_prot_pkg::sign_type grad_sign,
   input freq_prot_pkg::surge_count_type surge_phases,
   input logic block_in,
   input logic voltage_low,
   input logic phase_lost,
   input logic [freq_prot_pkg::FREQ_W-1:0] freq_a,
   input logic [freq_prot_pkg::FREQ_W-1:0] freq_b,
   input logic [freq_prot_pkg::FREQ_W-1:0] freq_c,
   input logic signed [freq_prot_pkg::GRAD_W-1:0] grad_a,
   input logic signed [freq_prot_pkg::GRAD_W-1:0] grad_b,
   input logic signed [freq_prot_pkg::GRAD_W-1:0] grad_c,
   input logic zero_cross_a,
   input logic zero_cross_b,
   input logic zero_cross_c,
   input logic [freq_prot_pkg::FREQ_W-1:0] freq_pickup_threshold,
   input logic [freq_prot_pkg::GRAD_W-2:0] freq_gradient_threshold,
   input logic [freq_prot_pkg::FREQ_W-1:0] freq_change_threshold,
   input logic [freq_prot_pkg::MS_W-1:0] supervision_interval,
   input logic [freq_prot_pkg::MS_W-1:0] trip_delay,
   input logic [freq_prot_pkg::CYC_W-1:0] surge_threshold,
   input logic [freq_prot_pkg::WIN_W-1:0] gradient_measure_window,
   output logic alarm,
   output logic trip,
   output logic frequency_blocked,
   output logic [freq_prot_pkg::FREQ_W-1:0] reported_freq,
   output logic [freq_prot_pkg::WIN_W-1:0] gradient_window_periods
);
   typedef struct packed {
      logic alarm;
      logic trip;
      logic inhibit;
      logic blocked;
      logic [2:0] prev_beyond;
      logic [2:0][freq_prot_pkg::FREQ_W-1:0] start_freq;
      logic [freq_prot_pkg::REC_W-1:0] recovery;
      logic [freq_prot_pkg::FREQ_W-1:0] report;
      logic [freq_prot_pkg::WIN_W-1:0] window;
   } element_state_type;

   element_state_type state;
   element_state_type next_state;

   logic [2:0][freq_prot_pkg::FREQ_W-1:0] freq;
   logic [2:0][freq_prot_pkg::GRAD_W-1:0] grad;
   logic [2:0] zero_cross;
   logic [2:0] beyond;
   logic [2:0] grad_hit;
   logic [2:0] change_hit;
   logic [2:0] surge_hit;
   logic [1:0] surge_sum;
   logic over;
   logic low_block;
   logic blocked;
   logic new_cross;
   logic pickup;
   logic surge_ok;
   logic surge_inhibit;
   logic timer_run;
   logic timer_expired;
   logic [freq_prot_pkg::MS_W-1:0] timer_limit;

   assign freq[0] = freq_a;
   assign freq[1] = freq_b;
   assign freq[2] = freq_c;
   assign grad[0] = grad_a;
   assign grad[1] = grad_b;
   assign grad[2] = grad_c;
   assign zero_cross[0] = zero_cross_a;
   assign zero_cross[1] = zero_cross_b;
   assign zero_cross[2] = zero_cross_c;

   // One cycle duration meter per phase.
   for (genvar i = 0; i < 3; i++)
   begin : g_meter
      surge_meter #(
         .LATENCY_CYCLES(SURGE_LATENCY_CYCLES)
      ) u_meter (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .hold(voltage_low),
         .zero_cross(zero_cross[i]),
         .threshold(surge_threshold),
         .surge(surge_hit[i])
      );
   end

   // Shared timer: trip delay in gradient modes, supervision interval in change modes.
   delay_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(timer_run),
      .limit_ms(timer_limit),
      .expired(timer_expired)
   );

   // Per-phase threshold evaluation.
   always_comb
   begin
      over = (mode == freq_prot_pkg::MODE_OVER_GRAD) || (mode == freq_prot_pkg::MODE_OVER_CHANGE);
      for (int i = 0; i < 3; i++)
      begin
         beyond[i] = freq_prot_pkg::beyond(freq[i], freq_pickup_threshold, over);
         grad_hit[i] = freq_prot_pkg::grad_violate(grad[i], freq_gradient_threshold, grad_sign);
         change_hit[i] = freq_prot_pkg::change_reached(state.start_freq[i], freq[i],
                                                       freq_change_threshold, over);
      end
   end

   assign surge_sum = 2'(surge_hit[0]) + 2'(surge_hit[1]) + 2'(surge_hit[2]);

   always_comb
   begin
      case (surge_phases)
         freq_prot_pkg::SURGE_ALL: surge_ok = surge_sum == 2'h3;
         freq_prot_pkg::SURGE_TWO: surge_ok = surge_sum >= 2'h2;
         freq_prot_pkg::SURGE_ONE: surge_ok = surge_sum >= 2'h1;
         default: surge_ok = 1'b0;
      endcase
   end

   // Undervoltage block is held after recovery.
   assign low_block = voltage_low || (state.recovery < freq_prot_pkg::REC_W'(BLOCK_HOLD_CYCLES));
   assign blocked = block_in || low_block;
   assign surge_inhibit = block_in || voltage_low || phase_lost;
   assign new_cross = |(beyond & ~state.prev_beyond);
   assign timer_run = next_state.alarm && (mode != freq_prot_pkg::MODE_SURGE);

   always_comb
   begin
      if ((mode == freq_prot_pkg::MODE_UNDER_CHANGE) || (mode == freq_prot_pkg::MODE_OVER_CHANGE))
         timer_limit = supervision_interval;
      else
         timer_limit = trip_delay;
   end

   always_comb
   begin
      next_state = state;
      pickup = 1'b0;
      next_state.prev_beyond = beyond;
      next_state.blocked = blocked;

      // Recovery timing after low voltage.
      if (voltage_low)
      begin
         next_state.recovery = freq_prot_pkg::RECOVERY_RESET;
      end
      else if (state.recovery < freq_prot_pkg::REC_W'(BLOCK_HOLD_CYCLES))
      begin
         next_state.recovery = state.recovery + 25'h0000001;
      end

      // Reported frequency is forced to zero during and after low voltage.
      if (voltage_low || (state.recovery < freq_prot_pkg::REC_W'(FREQ_ZERO_CYCLES)))
      begin
         next_state.report = freq_prot_pkg::REPORT_RESET;
      end
      else
      begin
         next_state.report = freq[0];
      end

      // Gradient window is clamped to its legal span.
      if (gradient_measure_window < freq_prot_pkg::WINDOW_MIN)
      begin
         next_state.window = freq_prot_pkg::WINDOW_MIN;
      end
      else if (gradient_measure_window > freq_prot_pkg::WINDOW_MAX)
      begin
         next_state.window = freq_prot_pkg::WINDOW_MAX;
      end
      else
      begin
         next_state.window = gradient_measure_window;
      end

      case (mode)
         freq_prot_pkg::MODE_GRADIENT:
         begin
            pickup = |grad_hit;
            next_state.alarm = pickup && !blocked;
            next_state.trip = pickup && !blocked && state.alarm && timer_expired;
            next_state.inhibit = 1'b0;
         end
         freq_prot_pkg::MODE_UNDER_GRAD:
         begin
            pickup = |(grad_hit & beyond);
            next_state.alarm = pickup && !blocked;
            next_state.trip = pickup && !blocked && state.alarm && timer_expired;
            next_state.inhibit = 1'b0;
         end
         freq_prot_pkg::MODE_OVER_GRAD:
         begin
            pickup = |(grad_hit & beyond);
            next_state.alarm = pickup && !blocked;
            next_state.trip = pickup && !blocked && state.alarm && timer_expired;
            next_state.inhibit = 1'b0;
         end
         freq_prot_pkg::MODE_UNDER_CHANGE, freq_prot_pkg::MODE_OVER_CHANGE:
         begin
            pickup = |beyond;
            if (blocked || !pickup)
            begin
               next_state.alarm = 1'b0;
               next_state.trip = 1'b0;
            end
            else if (new_cross && !state.alarm)
            begin
               next_state.alarm = 1'b1;
               next_state.trip = 1'b0;
               next_state.inhibit = 1'b0;
               next_state.start_freq = freq;
            end
            else if (state.inhibit)
            begin
               next_state.alarm = 1'b0;
               next_state.trip = 1'b0;
            end
            else if (state.trip)
            begin
               next_state.trip = 1'b1;
            end
            else if (|(beyond & change_hit) && !timer_expired)
            begin
               next_state.trip = 1'b1;
            end
            else if (timer_expired)
            begin
               next_state.alarm = 1'b0;
               next_state.inhibit = 1'b1;
            end
         end
         freq_prot_pkg::MODE_SURGE:
         begin
            pickup = surge_ok;
            next_state.alarm = surge_ok && !surge_inhibit;
            next_state.trip = surge_ok && !surge_inhibit;
            next_state.inhibit = 1'b0;
         end
         default:
         begin
            next_state.alarm = 1'b0;
            next_state.trip = 1'b0;
            next_state.inhibit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= '0;
         state.window <= freq_prot_pkg::WINDOW_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign alarm = state.alarm;
   assign trip = state.trip;
   assign frequency_blocked = state.blocked;
   assign reported_freq = state.report;
   assign gradient_window_periods = state.window;
endmodule // frequency_protection_element

// File: freq_prot_asserts.sv
// Concurrent checks on the ports of the frequency protection element.
`timescale 1ns/1ps
module freq_prot_asserts (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire freq_prot_pkg::mode_type mode,
   input wire freq_prot_pkg::sign_type grad_sign,
   input wire logic block_in,
   input wire logic voltage_low,
   input wire logic phase_lost,
   input wire logic [15:0] freq_a,
   input wire logic [15:0] freq_b,
   input wire logic [15:0] freq_c,
   input wire logic signed [15:0] grad_a,
   input wire logic signed [15:0] grad_b,
   input wire logic signed [15:0] grad_c,
   input wire logic [15:0] freq_pickup_threshold,
   input wire logic [14:0] freq_gradient_threshold,
   input wire logic [3:0] gradient_measure_window,
   input wire logic alarm,
   input wire logic trip,
   input wire logic frequency_blocked,
   input wire logic [3:0] gradient_window_periods
);
   logic signed [15:0] lim;
   logic [15:0] thr;
   logic pos;
   assign lim = $signed({1'b0, freq_gradient_threshold});
   assign thr = freq_pickup_threshold;
   assign pos = mode == freq_prot_pkg::MODE_GRADIENT && grad_sign == freq_prot_pkg::SIGN_POS;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   AST_BLOCK_CLEAR: assert property (block_in |=> !alarm && !trip)
      else $error("alarm or trip stayed up under block");
   AST_GRAD_PICKUP: assert property (pos && grad_a >= lim && !block_in && !voltage_low && !frequency_blocked
      ##1 !frequency_blocked |-> alarm) else $error("gradient pickup gave no alarm");
   AST_GRAD_QUIET: assert property (pos && grad_a < lim && grad_b < lim && grad_c < lim |=> !alarm)
      else $error("alarm without gradient violation");
   AST_UNDER_NEEDS_LOW: assert property (mode == freq_prot_pkg::MODE_UNDER_GRAD
      && freq_a >= thr && freq_b >= thr && freq_c >= thr |=> !alarm) else $error("alarm without low frequency");
   AST_OVER_NEEDS_HIGH: assert property (mode == freq_prot_pkg::MODE_OVER_GRAD
      && freq_a <= thr && freq_b <= thr && freq_c <= thr |=> !alarm) else $error("alarm without high frequency");
   AST_TRIP_AFTER_ALARM: assert property ($rose(trip) && $past(mode) == freq_prot_pkg::MODE_GRADIENT
      |-> $past(alarm)) else $error("gradient trip without earlier alarm");
   AST_SURGE_PAIR: assert property (mode == freq_prot_pkg::MODE_SURGE |=> alarm == trip)
      else $error("surge alarm and trip differ");
   AST_SURGE_LOST: assert property (mode == freq_prot_pkg::MODE_SURGE && phase_lost |=> !trip)
      else $error("surge trip with a lost phase");
   AST_SURGE_VLOW: assert property (mode == freq_prot_pkg::MODE_SURGE && voltage_low |=> !trip)
      else $error("surge trip at low voltage");
   AST_WINDOW: assert property (1'b1 |=> gradient_window_periods == ($past(gradient_measure_window) < 4'h2 ?
      4'h2 : $past(gradient_measure_window) > 4'hA ? 4'hA : $past(gradient_measure_window)))
      else $error("window not clamped");
endmodule // freq_prot_asserts

// File: front_end_model.sv
// Zero crossing source standing in for the voltage measurement front end.
`timescale 1ns/1ps
module front_end_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [15:0] period,
   output logic zero_cross
);
   logic [15:0] cnt;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 16'h0000;
         zero_cross <= 1'b0;
      end
      else if (cnt >= period - 16'h0001)
      begin
         cnt <= 16'h0000;
         zero_cross <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 16'h0001;
         zero_cross <= 1'b0;
      end
   end
endmodule // front_end_model

// File: testbench.sv
// Self-checking testbench of the frequency protection element.
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   freq_prot_pkg::mode_type mode = freq_prot_pkg::MODE_GRADIENT;
   freq_prot_pkg::sign_type grad_sign = freq_prot_pkg::SIGN_POS;
   freq_prot_pkg::surge_count_type surge_phases = freq_prot_pkg::SURGE_ALL;
   logic block_in = 1'b0;
   logic voltage_low = 1'b0;
   logic phase_lost = 1'b0;
   logic [15:0] freq [3] = '{16'h1388, 16'h1388, 16'h1388};
   logic signed [15:0] grad [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic [15:0] period = 16'h0028;
   logic [15:0] trip_delay = 16'h0001;
   logic [3:0] window = 4'h2;
   logic zc;
   logic zc_c_on = 1'b1;
   logic [15:0] freq_pickup_threshold = 16'h1388;
   logic [14:0] freq_gradient_threshold = 15'h0064;
   logic [15:0] freq_change_threshold = 16'h0064;
   logic [15:0] supervision_interval = 16'h0002;
   logic [23:0] surge_threshold = 24'h000004;
   logic alarm;
   logic trip;
   logic frequency_blocked;
   logic [15:0] reported_freq;
   logic [3:0] gradient_window_periods;
   int cycles = 0;
   int mismatches = 0;
   int checks = 0;
   frequency_protection_element #(.MS_CYCLES(4), .BLOCK_HOLD_CYCLES(20), .FREQ_ZERO_CYCLES(12),
      .SURGE_LATENCY_CYCLES(200)) frequency_protection_element_i (.ref_clk(ref_clk), .nrst(nrst),
      .mode(mode), .grad_sign(grad_sign), .surge_phases(surge_phases), .block_in(block_in),
      .voltage_low(voltage_low), .phase_lost(phase_lost), .freq_a(freq[0]), .freq_b(freq[1]),
      .freq_c(freq[2]), .grad_a(grad[0]), .grad_b(grad[1]), .grad_c(grad[2]), .zero_cross_a(zc),
      .zero_cross_b(zc), .zero_cross_c(zc & zc_c_on), .freq_pickup_threshold(freq_pickup_threshold),
      .freq_gradient_threshold(freq_gradient_threshold), .freq_change_threshold(freq_change_threshold),
      .supervision_interval(supervision_interval), .trip_delay(trip_delay), .surge_threshold(surge_threshold),
      .gradient_measure_window(window),
      .alarm(alarm), .trip(trip), .frequency_blocked(frequency_blocked), .reported_freq(reported_freq),
      .gradient_window_periods(gradient_window_periods));
   front_end_model front_end_model_i (.ref_clk(ref_clk), .nrst(nrst), .period(period), .zero_cross(zc));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic window_run();
      logic [3:0] e;
      for (int i = 0; i < 16; i++)
      begin
         e = (i < 2) ? 4'h2 : (i > 10) ? 4'hA : 4'(i);
         @(posedge ref_clk);
         window <= 4'(i);
         wt(2);
         chk(gradient_window_periods, e, "window clamp");
      end
      $display("window test done");
   endtask
   task automatic recovery_run();
      @(posedge ref_clk);
      voltage_low <= 1'b1;
      wt(3);
      chk(reported_freq, 16'h0000, "zero at low voltage");
      @(posedge ref_clk);
      voltage_low <= 1'b0;
      wt(10);
      chk({frequency_blocked, reported_freq}, 17'h10000, "holds after recovery");
      wt(10);
      chk({frequency_blocked, reported_freq}, {1'b1, freq[0]}, "block outlasts zero");
      wt(5);
      chk({frequency_blocked, reported_freq}, {1'b0, freq[0]}, "holds released");
      $display("recovery test done");
   endtask
   task automatic pick_run(input freq_prot_pkg::mode_type m, input freq_prot_pkg::sign_type s,
                           input int p, input int g, input int f, input logic exp);
      @(posedge ref_clk);
      mode <= m;
      grad_sign <= s;
      grad[p] <= 16'(g);
      freq[p] <= 16'(f);
      wt(1);
      chk({alarm, trip}, {exp, 1'b0}, "alarm before delay");
      wt(10);
      chk(trip, exp, "trip after delay");
      @(posedge ref_clk);
      block_in <= 1'b1;
      wt(2);
      chk({alarm, trip}, 2'b00, "block clears");
      @(posedge ref_clk);
      block_in <= 1'b0;
      grad[p] <= 16'h0000;
      freq[p] <= 16'h1388;
      wt(3);
      $display("pickup test done");
   endtask
   task automatic step_freq(input int f, input int n);
      @(posedge ref_clk);
      freq[0] <= 16'(f);
      wt(n);
   endtask
   task automatic change_run(input freq_prot_pkg::mode_type m, input int d);
      @(posedge ref_clk);
      mode <= m;
      step_freq(5000 + d * 10, 2);
      chk(alarm, 1'b1, "alarm on crossing");
      step_freq(5000 + d * 120, 2);
      chk(trip, 1'b1, "trip on change");
      step_freq(5000, 3);
      chk(trip, 1'b0, "trip gone on return");
      step_freq(5000 + d * 300, 2);
      chk(alarm, 1'b1, "alarm on far crossing");
      step_freq(5000 + d * 150, 3);
      chk(trip, 1'b0, "change the wrong way");
      wt(20);
      chk(alarm, 1'b0, "interval expired");
      step_freq(5000 + d * 400, 3);
      chk(trip, 1'b0, "inhibited after expiry");
      step_freq(5000, 2);
      step_freq(5000 + d * 10, 2);
      chk(alarm, 1'b1, "new crossing");
      step_freq(5000, 3);
      $display("change test done");
   endtask
   task automatic surge_run(input int c, input logic vl, input logic pl, input int first, input int inc,
                            input logic exp);
      logic seen;
      int n;
      int lat;
      seen = 1'b0;
      n = 0;
      lat = 0;
      @(posedge ref_clk);
      mode <= freq_prot_pkg::MODE_SURGE;
      surge_phases <= freq_prot_pkg::surge_count_type'(c);
      voltage_low <= vl;
      phase_lost <= pl;
      period <= 16'h0028;
      while (n < 10)
      begin
         wt(1);
         seen = seen | (trip === 1'b1);
         lat = lat + int'(n >= 4 && !seen);
         if (zc === 1'b1)
         begin
            n++;
            seen = seen & (n > 4);
            if (n >= 4)
               period <= 16'(first + (n - 4) * inc);
         end
      end
      chk(seen, exp, "surge trip");
      if (exp)
         chk(lat < 30, 1'b1, "surge latency");
      $display("surge test done");
   endtask
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   initial
   begin
      wt(2);
      chk(gradient_window_periods, 4'h2, "window in reset");
      @(posedge ref_clk);
      nrst <= 1'b1;
      wt(30);
      window_run();
      recovery_run();
      for (int i = 0; i < 6; i++)
         pick_run(freq_prot_pkg::MODE_GRADIENT, freq_prot_pkg::sign_type'(i / 2), i % 3, (i % 2) ? -150 : 150,
                  5000, (i / 2 == 2) || ((i / 2 == 0) == (i % 2 == 0)));
      pick_run(freq_prot_pkg::MODE_GRADIENT, freq_prot_pkg::SIGN_POS, 0, 100, 5000, 1'b1);
      pick_run(freq_prot_pkg::MODE_GRADIENT, freq_prot_pkg::SIGN_POS, 1, 99, 5000, 1'b0);
      @(posedge ref_clk);
      trip_delay <= 16'h0000;
      for (int i = 0; i < 4; i++)
         pick_run(freq_prot_pkg::mode_type'(1 + i / 2), freq_prot_pkg::SIGN_POS, i % 3, 150,
                  ((i < 2) == (i % 2 == 0)) ? 4000 : 6000, i % 2 == 0);
      change_run(freq_prot_pkg::MODE_UNDER_CHANGE, -1);
      change_run(freq_prot_pkg::MODE_OVER_CHANGE, 1);
      for (int i = 0; i < 3; i++)
         surge_run(i, 1'b0, 1'b0, 25, 0, 1'b1);
      @(posedge ref_clk);
      zc_c_on <= 1'b0;
      surge_run(0, 1'b0, 1'b0, 41, 1, 1'b0);
      surge_run(0, 1'b0, 1'b1, 25, 0, 1'b0);
      surge_run(0, 1'b1, 1'b0, 25, 0, 1'b0);
      surge_run(0, 1'b0, 1'b0, 25, 0, 1'b0);
      surge_run(1, 1'b0, 1'b0, 25, 0, 1'b1);
      wrap_up();
   end
endmodule // testbench
bind frequency_protection_element freq_prot_asserts freq_prot_asserts_i (.ref_clk(ref_clk), .nrst(nrst),
   .mode(mode), .grad_sign(grad_sign), .block_in(block_in), .voltage_low(voltage_low), .phase_lost(phase_lost),
   .freq_a(freq_a), .freq_b(freq_b), .freq_c(freq_c), .grad_a(grad_a), .grad_b(grad_b), .grad_c(grad_c),
   .freq_pickup_threshold(freq_pickup_threshold), .freq_gradient_threshold(freq_gradient_threshold),
   .gradient_measure_window(gradient_measure_window), .alarm(alarm), .trip(trip),
   .frequency_blocked(frequency_blocked), .gradient_window_periods(gradient_window_periods));
